// ===== src/scbd_pkg.sv
// Constants and types shared by the command decoder and the controller end
package scbd_pkg;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 8000;
    localparam int PRECHARGE_PERIOD_NS = 15;
    localparam int ACTIVATE_TO_ACCESS_DELAY_NS = 15;
    localparam int SELF_REFRESH_EXIT_INTERVAL_NS = 200;
    localparam int SELF_REFRESH_EXIT_NO_READ_INTERVAL_NS = 120;
    localparam int PD_NOP_HOLD_NS = 10;
    localparam int BURST_LENGTH = 4;
    localparam int READ_TAIL_CYC = 2;
    localparam int WRITE_TAIL_CYC = 2;
    // Least times round up to whole cycles
    localparam int PRECHARGE_PERIOD_CYC = (PRECHARGE_PERIOD_NS * 1000 + CLK_PERIOD_PS - 1)
        / CLK_PERIOD_PS;
    localparam int ACTIVATE_TO_ACCESS_DELAY_CYC =
        (ACTIVATE_TO_ACCESS_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int SELF_REFRESH_EXIT_INTERVAL_CYC =
        (SELF_REFRESH_EXIT_INTERVAL_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int SELF_REFRESH_EXIT_NO_READ_INTERVAL_CYC =
        (SELF_REFRESH_EXIT_NO_READ_INTERVAL_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int PD_NOP_HOLD_CYC = (PD_NOP_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // Read burst done after half burst plus postamble tail; write adds half burst more
    localparam int READ_BURST_CYC = BURST_LENGTH / 2 + READ_TAIL_CYC;
    localparam int WRITE_BURST_CYC = BURST_LENGTH / 2 + WRITE_TAIL_CYC + BURST_LENGTH / 2;
    localparam int NUM_BANKS = 4;
    localparam int CNT_W = 8;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        SCBD_CMD_DESELECT,
        SCBD_CMD_NOP,
        SCBD_CMD_TERM_DISABLE,
        SCBD_CMD_ACTIVE,
        SCBD_CMD_READ,
        SCBD_CMD_WRITE,
        SCBD_CMD_PRECHARGE,
        SCBD_CMD_AUTO_REFRESH,
        SCBD_CMD_LOAD_MODE
    } scbd_cmd_e;

    typedef enum logic [2:0] {
        SCBD_BANK_IDLE,
        SCBD_BANK_ACTIVATING,
        SCBD_BANK_ACTIVE,
        SCBD_BANK_READ,
        SCBD_BANK_WRITE,
        SCBD_BANK_PRECHARGING
    } scbd_bank_e;

    typedef enum logic [1:0] {
        SCBD_PWR_NORMAL,
        SCBD_PWR_PRECHARGE_PD,
        SCBD_PWR_ACTIVE_PD,
        SCBD_PWR_SELF_REFRESH
    } scbd_pwr_e;

    // Decodes the four active-low command pins
    function automatic scbd_cmd_e decode_cmd(input logic cs_n, input logic ras_n,
                                             input logic cas_n, input logic we_n);
        scbd_cmd_e c;
        c = SCBD_CMD_NOP;
        if (ras_n && !cas_n && we_n && cs_n) begin
            c = SCBD_CMD_TERM_DISABLE;
        end else if (cs_n) begin
            c = SCBD_CMD_DESELECT;
        end else begin
            unique case ({ras_n, cas_n, we_n})
                3'h7: c = SCBD_CMD_NOP;
                3'h3: c = SCBD_CMD_ACTIVE;
                3'h5: c = SCBD_CMD_READ;
                3'h4: c = SCBD_CMD_WRITE;
                3'h2: c = SCBD_CMD_PRECHARGE;
                3'h1: c = SCBD_CMD_AUTO_REFRESH;
                3'h0: c = SCBD_CMD_LOAD_MODE;
                3'h6: c = SCBD_CMD_TERM_DISABLE;
            endcase
        end
        return c;
    endfunction : decode_cmd
endpackage : scbd_pkg

// ===== src/scbd_if.sv
// Command pins between controller and DRAM decoder
`timescale 1ns/1ps
interface scbd_if;
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic ap;
    logic [1:0] bank;

    modport ctrl (
        output cke,
        output cs_n,
        output ras_n,
        output cas_n,
        output we_n,
        output ap,
        output bank
    );
    modport dev (
        input cke,
        input cs_n,
        input ras_n,
        input cas_n,
        input we_n,
        input ap,
        input bank
    );
endinterface : scbd_if

// ===== src/scbd_device.sv
// Device end: command decode, power state and per-bank state tracking
`timescale 1ns/1ps
module scbd_device #(
    parameter int PRE_CYC = scbd_pkg::PRECHARGE_PERIOD_CYC,
    parameter int ACT_CYC = scbd_pkg::ACTIVATE_TO_ACCESS_DELAY_CYC,
    parameter int RD_CYC = scbd_pkg::READ_BURST_CYC,
    parameter int WR_CYC = scbd_pkg::WRITE_BURST_CYC
) (
    input wire logic clk,
    input wire logic sys_rst,
    scbd_if.dev pins,
    output logic [11:0] bank_state,
    output logic [1:0] pwr_state,
    output logic cmd_illegal,
    output logic term_disable
);
    localparam int NB = scbd_pkg::NUM_BANKS;
    localparam int CW = scbd_pkg::CNT_W;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0] sync_a;
        logic [1:0] sync_b;
        logic [4:0] cmd_a;
        logic [4:0] cmd_b;
        logic [1:0] bank_a;
        logic [1:0] bank_b;
        logic cke_prev;
        scbd_pkg::scbd_pwr_e pwr;
        scbd_pkg::scbd_bank_e [NB-1:0] bank_st;
        logic [NB-1:0][CW-1:0] cnt;
        logic illegal;
        logic tdis;
    } scbd_dev_s;

    scbd_dev_s st_q;
    scbd_dev_s st_d;

    function automatic logic [CW-1:0] cyc(input int n);
        return (n > 1) ? CW'(n - 1) : '0;
    endfunction : cyc

    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic ap;
    logic [1:0] ba;
    scbd_pkg::scbd_cmd_e cmd;
    logic all_idle;

    always_comb begin
        {cke, cs_n, ras_n, cas_n, we_n} = st_q.cmd_b;
        {ap, ba} = {st_q.sync_b[0], st_q.bank_b};
        cmd = scbd_pkg::decode_cmd(cs_n, ras_n, cas_n, we_n);
        all_idle = 1'b1;
        for (int i = 0; i < NB; i++) begin
            if (st_q.bank_st[i] != scbd_pkg::SCBD_BANK_IDLE) begin
                all_idle = 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        // Pins pass two flops before use
        st_d.cmd_a = {pins.cke, pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n};
        st_d.cmd_b = st_q.cmd_a;
        st_d.sync_a = {1'b0, pins.ap};
        st_d.sync_b = st_q.sync_a;
        st_d.bank_a = pins.bank;
        st_d.bank_b = st_q.bank_a;
        st_d.cke_prev = cke;
        st_d.illegal = 1'b0;
        st_d.tdis = (cmd == scbd_pkg::SCBD_CMD_TERM_DISABLE);
        // Timers run out and banks settle
        for (int i = 0; i < NB; i++) begin
            if (st_q.cnt[i] != '0) begin
                st_d.cnt[i] = st_q.cnt[i] - CW'(1);
            end else begin
                unique case (st_q.bank_st[i])
                    scbd_pkg::SCBD_BANK_PRECHARGING: st_d.bank_st[i] = scbd_pkg::SCBD_BANK_IDLE;
                    scbd_pkg::SCBD_BANK_ACTIVATING: st_d.bank_st[i] = scbd_pkg::SCBD_BANK_ACTIVE;
                    scbd_pkg::SCBD_BANK_READ,
                    scbd_pkg::SCBD_BANK_WRITE: st_d.bank_st[i] = scbd_pkg::SCBD_BANK_ACTIVE;
                    default: ;
                endcase
            end
        end
        if (!st_q.cke_prev && !cke) begin
            // Low on both edges: stay where we are
            st_d.pwr = st_q.pwr;
        end else if (!st_q.cke_prev && cke) begin
            if (cmd == scbd_pkg::SCBD_CMD_DESELECT || cmd == scbd_pkg::SCBD_CMD_NOP) begin
                st_d.pwr = scbd_pkg::SCBD_PWR_NORMAL;
            end else begin
                st_d.illegal = 1'b1;
            end
        end else if (st_q.cke_prev && !cke) begin
            if (all_idle && cmd == scbd_pkg::SCBD_CMD_AUTO_REFRESH) begin
                st_d.pwr = scbd_pkg::SCBD_PWR_SELF_REFRESH;
            end else if (cmd == scbd_pkg::SCBD_CMD_DESELECT || cmd == scbd_pkg::SCBD_CMD_NOP) begin
                st_d.pwr = all_idle ? scbd_pkg::SCBD_PWR_PRECHARGE_PD
                                    : scbd_pkg::SCBD_PWR_ACTIVE_PD;
            end else begin
                st_d.illegal = 1'b1;
            end
        end else begin
            // Bank table only with clock enable high on both edges
            unique case (cmd)
                scbd_pkg::SCBD_CMD_ACTIVE: begin
                    if (st_q.bank_st[ba] == scbd_pkg::SCBD_BANK_IDLE) begin
                        st_d.bank_st[ba] = scbd_pkg::SCBD_BANK_ACTIVATING;
                        st_d.cnt[ba] = cyc(ACT_CYC);
                    end else begin
                        st_d.illegal = 1'b1;
                    end
                end
                scbd_pkg::SCBD_CMD_READ,
                scbd_pkg::SCBD_CMD_WRITE: begin
                    if (st_q.bank_st[ba] == scbd_pkg::SCBD_BANK_ACTIVE ||
                        st_q.bank_st[ba] == scbd_pkg::SCBD_BANK_READ ||
                        st_q.bank_st[ba] == scbd_pkg::SCBD_BANK_WRITE) begin
                        if (ap) begin
                            st_d.bank_st[ba] = scbd_pkg::SCBD_BANK_PRECHARGING;
                            st_d.cnt[ba] = cyc((cmd == scbd_pkg::SCBD_CMD_READ ? RD_CYC : WR_CYC)
                                               + PRE_CYC);
                        end else if (cmd == scbd_pkg::SCBD_CMD_READ) begin
                            st_d.bank_st[ba] = scbd_pkg::SCBD_BANK_READ;
                            st_d.cnt[ba] = cyc(RD_CYC);
                        end else begin
                            st_d.bank_st[ba] = scbd_pkg::SCBD_BANK_WRITE;
                            st_d.cnt[ba] = cyc(WR_CYC);
                        end
                    end else begin
                        st_d.illegal = 1'b1;
                    end
                end
                scbd_pkg::SCBD_CMD_PRECHARGE: begin
                    // Auto-precharge bit selects all banks
                    for (int i = 0; i < NB; i++) begin
                        if (ap || ba == 2'(i)) begin
                            if (st_q.bank_st[i] == scbd_pkg::SCBD_BANK_ACTIVE) begin
                                st_d.bank_st[i] = scbd_pkg::SCBD_BANK_PRECHARGING;
                                st_d.cnt[i] = cyc(PRE_CYC);
                            end else if (st_q.bank_st[i] != scbd_pkg::SCBD_BANK_IDLE) begin
                                st_d.illegal = 1'b1;
                            end
                        end
                    end
                end
                scbd_pkg::SCBD_CMD_AUTO_REFRESH,
                scbd_pkg::SCBD_CMD_LOAD_MODE: begin
                    st_d.illegal = !all_idle;
                end
                scbd_pkg::SCBD_CMD_DESELECT,
                scbd_pkg::SCBD_CMD_NOP,
                scbd_pkg::SCBD_CMD_TERM_DISABLE: ;
            endcase
        end
        if (sys_rst) begin
            st_d = '0;
            st_d.cmd_a = 5'h1f;
            st_d.cmd_b = 5'h1f;
            st_d.cke_prev = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        st_q <= st_d;
    end

    always_comb begin
        for (int i = 0; i < NB; i++) begin
            bank_state[3*i +: 3] = st_q.bank_st[i];
        end
    end
    assign pwr_state = st_q.pwr;
    assign cmd_illegal = st_q.illegal;
    assign term_disable = st_q.tdis;
endmodule : scbd_device

// ===== src/scbd_controller.sv
// Controller end: drives one command at a time and respects interval waits
`timescale 1ns/1ps
module scbd_controller #(
    parameter int SRX_CYC = scbd_pkg::SELF_REFRESH_EXIT_INTERVAL_CYC,
    parameter int PD_CYC = scbd_pkg::PD_NOP_HOLD_CYC,
    parameter int RD_CYC = scbd_pkg::READ_BURST_CYC,
    parameter int WR_CYC = scbd_pkg::WRITE_BURST_CYC,
    parameter int GAP_CYC = scbd_pkg::ACTIVATE_TO_ACCESS_DELAY_CYC + 4
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic req_valid,
    input wire logic [3:0] req_cmd,
    input wire logic [1:0] req_bank,
    input wire logic req_ap,
    input wire logic req_cke,
    output logic req_ready,
    scbd_if.ctrl pins
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic cke;
        logic [3:0] cs_ras_cas_we;
        logic ap;
        logic [1:0] bank;
        logic [7:0] wait_cnt;
        logic [7:0] burst_cnt;
        logic was_sr;
    } scbd_ctl_s;

    scbd_ctl_s st_q;
    scbd_ctl_s st_d;

    function automatic logic [7:0] cyc(input int n);
        return (n > 1) ? 8'(n - 1) : 8'h00;
    endfunction : cyc

    function automatic logic [3:0] encode(input scbd_pkg::scbd_cmd_e c);
        logic [3:0] p;
        p = 4'h7;
        unique case (c)
            scbd_pkg::SCBD_CMD_DESELECT: p = 4'hf;
            scbd_pkg::SCBD_CMD_ACTIVE: p = 4'h3;
            scbd_pkg::SCBD_CMD_READ: p = 4'h5;
            scbd_pkg::SCBD_CMD_WRITE: p = 4'h4;
            scbd_pkg::SCBD_CMD_PRECHARGE: p = 4'h2;
            scbd_pkg::SCBD_CMD_AUTO_REFRESH: p = 4'h1;
            scbd_pkg::SCBD_CMD_LOAD_MODE: p = 4'h0;
            scbd_pkg::SCBD_CMD_TERM_DISABLE: p = 4'hd;
            default: p = 4'h7;
        endcase
        return p;
    endfunction : encode

    scbd_pkg::scbd_cmd_e rc;
    logic busy;

    always_comb begin
        rc = scbd_pkg::scbd_cmd_e'(req_cmd);
        // Hold no-ops through exit and hold intervals; clock enable stays up in bursts
        busy = (st_q.wait_cnt != 8'h00) ||
               (st_q.burst_cnt != 8'h00 && !req_cke) ||
               (st_q.burst_cnt != 8'h00 && rc == scbd_pkg::SCBD_CMD_PRECHARGE);
        req_ready = !busy;
    end

    always_comb begin
        st_d = st_q;
        st_d.cs_ras_cas_we = 4'h7;
        st_d.ap = 1'b0;
        if (st_q.wait_cnt != 8'h00) begin
            st_d.wait_cnt = st_q.wait_cnt - 8'h01;
        end
        if (st_q.burst_cnt != 8'h00) begin
            st_d.burst_cnt = st_q.burst_cnt - 8'h01;
        end
        if (req_valid && !busy) begin
            st_d.cke = req_cke;
            st_d.bank = req_bank;
            st_d.ap = req_ap;
            if (st_q.cke != req_cke) begin
                // Clock enable edges travel with no-op, or refresh to enter self refresh
                st_d.cs_ras_cas_we = (!req_cke && rc == scbd_pkg::SCBD_CMD_AUTO_REFRESH)
                                   ? encode(rc) : 4'h7;
                st_d.was_sr = !req_cke && rc == scbd_pkg::SCBD_CMD_AUTO_REFRESH;
                st_d.wait_cnt = req_cke ? (st_q.was_sr ? cyc(SRX_CYC) : 8'h00)
                                        : cyc(PD_CYC);
            end else if (req_cke) begin
                st_d.cs_ras_cas_we = encode(rc);
                if (rc == scbd_pkg::SCBD_CMD_READ) begin
                    // Full burst length: the decoder leaves the burst state one edge later
                    st_d.burst_cnt = 8'(RD_CYC);
                end else if (rc == scbd_pkg::SCBD_CMD_WRITE) begin
                    st_d.burst_cnt = 8'(WR_CYC);
                end else if (rc == scbd_pkg::SCBD_CMD_ACTIVE ||
                             rc == scbd_pkg::SCBD_CMD_PRECHARGE) begin
                    st_d.wait_cnt = cyc(GAP_CYC);
                end
            end
        end
        if (sys_rst) begin
            st_d = '0;
            st_d.cke = 1'b1;
            st_d.cs_ras_cas_we = 4'hf;
        end
    end

    always_ff @(posedge clk) begin
        st_q <= st_d;
    end

    assign pins.cke = st_q.cke;
    assign {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} = st_q.cs_ras_cas_we;
    assign pins.ap = st_q.ap;
    assign pins.bank = st_q.bank;
endmodule : scbd_controller

// ===== dv/scbd_properties.sv
// Checker of the command pins against the decoder outputs
`timescale 1ns/1ps
module scbd_properties #(
    parameter int ACT_CYC = scbd_pkg::ACTIVATE_TO_ACCESS_DELAY_CYC,
    parameter int PRE_CYC = scbd_pkg::PRECHARGE_PERIOD_CYC
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic ap,
    input wire logic [1:0] bank,
    input wire logic [11:0] bank_state,
    input wire logic [1:0] pwr_state,
    input wire logic cmd_illegal,
    input wire logic term_disable
);
    // ------
    // Command patterns
    // ------
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    wire [3:0] c = {cs_n, ras_n, cas_n, we_n};
    // Chip-select high with this pattern is term disable, which takes precedence over deselect
    wire tdis = c == 4'hd;
    wire quiet = (cs_n && !tdis) || c == 4'h7;
    wire act = c == 4'h3;
    wire rd = c == 4'h5 && !ap;
    wire aref = c == 4'h1;
    wire pre = c == 4'h2;

    // Bank state before decode and after it
    property p_bank(logic go, logic [2:0] s0, logic [2:0] s1);
        logic [1:0] b;
        (go && cke && $past(cke), b = bank) ##2 (bank_state[3*b +: 3] == s0 && pwr_state == 2'h0)
            |-> ##1 bank_state[3*b +: 3] == s1;
    endproperty

    // ------
    // Assertions
    // ------
    chk_term_decode: assert property (tdis |-> ##3 term_disable)
        else $error("term disable missed");
    chk_quiet_cmd: assert property (quiet && cke == $past(cke) |-> ##3 !cmd_illegal && !term_disable)
        else $error("quiet command flagged");
    chk_act_start: assert property (p_bank(act, 3'h0, 3'h1))
        else $error("activate not taken");
    chk_read_start: assert property (p_bank(rd, 3'h2, 3'h3))
        else $error("read not taken");
    chk_pd_entry: assert property ((cke == 1'b0 && $past(cke) && quiet) ##2
        (bank_state == 12'h0 && pwr_state == 2'h0) |-> ##1 pwr_state == 2'h1)
        else $error("power-down entry wrong");
    chk_sr_entry: assert property ((cke == 1'b0 && $past(cke) && aref) ##2
        (bank_state == 12'h0 && pwr_state == 2'h0) |-> ##1 pwr_state == 2'h3)
        else $error("self refresh entry wrong");
    chk_lp_exit: assert property ((cke && !$past(cke) && quiet) ##2 (pwr_state != 2'h0)
        |-> ##1 pwr_state == 2'h0)
        else $error("low power exit wrong");
    chk_lp_hold: assert property ((!cke && !$past(cke)) ##2 (pwr_state != 2'h0)
        |-> ##1 $stable(pwr_state))
        else $error("low power not held");
    for (genvar i = 0; i < 4; i++) begin : g_bank
        wire [2:0] s = bank_state[3*i +: 3];
        chk_act_time: assert property ($rose(s == 3'h1) |-> ##ACT_CYC s == 3'h2)
            else $error("activate delay wrong");
        chk_pre_time: assert property ($rose(s == 3'h5) && $past(pre, 3) |-> ##PRE_CYC s == 3'h0)
            else $error("precharge period wrong");
    end
    cover property (pwr_state == 2'h2);
    cover property (pwr_state == 2'h3);
    cover property (cmd_illegal);
endmodule : scbd_properties

// ===== dv/sdram_command_bank_state_decoder_test.sv
// Bench joining the controller end to the decoder end
`timescale 1ns/1ps
module sdram_command_bank_state_decoder_test;
    localparam int ACT = scbd_pkg::ACTIVATE_TO_ACCESS_DELAY_CYC;
    localparam int PRE = scbd_pkg::PRECHARGE_PERIOD_CYC;
    localparam int SRX = scbd_pkg::SELF_REFRESH_EXIT_INTERVAL_CYC;
    localparam logic [3:0] ENC [9] = '{4'hf, 4'h7, 4'h5, 4'h3, 4'h5, 4'h4, 4'h2, 4'h1, 4'h0};
    logic clk;
    logic sys_rst;
    logic req_valid;
    logic [3:0] req_cmd;
    logic [1:0] req_bank;
    logic req_ap;
    logic req_cke;
    logic req_ready;
    wire [15:0] out;
    wire [15:0] out2;
    int errors;
    int n_checks;
    int cyc = 0;
    int t0;
    scbd_if pins ();
    scbd_if pins2 ();
    scbd_controller scbd_controller_inst (.clk(clk), .sys_rst(sys_rst), .req_valid(req_valid),
        .req_cmd(req_cmd), .req_bank(req_bank), .req_ap(req_ap), .req_cke(req_cke),
        .req_ready(req_ready), .pins(pins.ctrl));
    scbd_device #(.PRE_CYC(PRE), .ACT_CYC(ACT)) scbd_device_inst (.clk(clk), .sys_rst(sys_rst),
        .pins(pins.dev), .bank_state(out[11:0]), .pwr_state(out[15:14]),
        .cmd_illegal(out[13]), .term_disable(out[12]));
    // Second decoder faced by the bench, for commands that break the rules
    scbd_device #(.PRE_CYC(PRE), .ACT_CYC(ACT)) scbd_device_inst2 (.clk(clk), .sys_rst(sys_rst),
        .pins(pins2.dev), .bank_state(out2[11:0]), .pwr_state(out2[15:14]),
        .cmd_illegal(out2[13]), .term_disable(out2[12]));
    scbd_properties #(.ACT_CYC(ACT), .PRE_CYC(PRE)) scbd_properties_inst (.clk(clk),
        .sys_rst(sys_rst), .cke(pins.cke), .cs_n(pins.cs_n), .ras_n(pins.ras_n),
        .cas_n(pins.cas_n), .we_n(pins.we_n), .ap(pins.ap), .bank(pins.bank),
        .bank_state(out[11:0]), .pwr_state(out[15:14]), .cmd_illegal(out[13]),
        .term_disable(out[12]));

    // ------
    // Tasks
    // ------
    task automatic finish_test();
        if (errors == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk

    task automatic step(input int n);
        req_valid = 1'b0;
        repeat (n) @(negedge clk);
    endtask : step

    // Request held until taken; valid stays up so calls may follow back to back
    task automatic send(input logic [3:0] c, input logic [1:0] b, input logic a, input logic k);
        int n = 0;
        logic [4:0] m;
        m = (c == 4'h0) ? 5'h07 : (c == 4'h2) ? 5'h08 : 5'h00;
        req_cmd = c;
        req_bank = b;
        req_ap = a;
        req_cke = k;
        req_valid = 1'b1;
        #1;
        while (req_ready !== 1'b1) begin
            n++;
            if (n > 400) begin
                errors++;
                finish_test();
            end
            @(negedge clk);
            #1;
        end
        @(negedge clk);
        chk("command pins", {pins.cke, pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} | m,
            {k, ENC[c]} | m);
    endtask : send

    task automatic op(input logic [3:0] c, input logic [1:0] b, input logic a, input logic k,
                      input logic [15:0] exp);
        send(c, b, a, k);
        step(3);
        chk("device outputs", out, exp);
    endtask : op

    task automatic drive2(input logic [3:0] c);
        {pins2.cs_n, pins2.ras_n, pins2.cas_n, pins2.we_n} = c;
        @(negedge clk);
    endtask : drive2

    // ------
    // Sequence
    // ------
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;

    initial begin
        errors = 0;
        n_checks = 0;
        sys_rst = 1'b1;
        req_valid = 1'b0;
        req_cmd = 4'h1;
        req_bank = 2'h0;
        req_ap = 1'b0;
        req_cke = 1'b1;
        pins2.cke = 1'b1;
        pins2.ap = 1'b0;
        pins2.bank = 2'h0;
        {pins2.cs_n, pins2.ras_n, pins2.cas_n, pins2.we_n} = 4'hf;
        repeat (20) @(negedge clk);
        sys_rst = 1'b0;
        step(1);
        chk("reset outputs", out, 16'h0000);
        op(4'h3, 2'h1, 1'b0, 1'b1, 16'h0008);
        step(ACT);
        chk("row active", out, 16'h0010);
        send(4'h4, 2'h1, 1'b0, 1'b1);
        send(4'h5, 2'h1, 1'b0, 1'b1);
        send(4'h4, 2'h1, 1'b0, 1'b1);
        step(1);
        chk("read state", out, 16'h0018);
        step(1);
        chk("write after read", out, 16'h0020);
        step(1);
        chk("read after write", out, 16'h0018);
        step(12);
        chk("burst done", out, 16'h0010);
        op(4'h6, 2'h1, 1'b0, 1'b1, 16'h0028);
        step(PRE);
        chk("precharged", out, 16'h0000);
        op(4'h3, 2'h0, 1'b0, 1'b1, 16'h0001);
        op(4'h3, 2'h2, 1'b0, 1'b1, 16'h0042);
        step(ACT);
        op(4'h8, 2'h0, 1'b0, 1'b1, 16'h2082);
        op(4'h6, 2'h0, 1'b1, 1'b1, 16'h0145);
        step(PRE);
        chk("all precharged", out, 16'h0000);
        op(4'h4, 2'h3, 1'b0, 1'b1, 16'h2000);
        for (int i = 0; i < 3; i++) begin
            op(i[3:0], 2'h1, 1'b0, 1'b1, (i == 2) ? 16'h1000 : 16'h0000);
        end
        op(4'h7, 2'h0, 1'b0, 1'b1, 16'h0000);
        op(4'h8, 2'h0, 1'b0, 1'b1, 16'h0000);
        op(4'h1, 2'h0, 1'b0, 1'b0, 16'h4000);
        step(4);
        chk("power-down held", out, 16'h4000);
        op(4'h1, 2'h0, 1'b0, 1'b1, 16'h0000);
        op(4'h3, 2'h2, 1'b0, 1'b1, 16'h0040);
        step(ACT);
        op(4'h1, 2'h0, 1'b0, 1'b0, 16'h8080);
        op(4'h1, 2'h0, 1'b0, 1'b1, 16'h0080);
        op(4'h6, 2'h2, 1'b0, 1'b1, 16'h0140);
        step(PRE);
        op(4'h7, 2'h0, 1'b0, 1'b0, 16'hc000);
        step(4);
        chk("self refresh held", out, 16'hc000);
        send(4'h1, 2'h0, 1'b0, 1'b1);
        t0 = cyc;
        op(4'h3, 2'h3, 1'b0, 1'b1, 16'h0200);
        chk("exit interval", (cyc - t0 - 3 >= SRX) ? 16'h1 : 16'h0, 16'h1);
        drive2(4'hd);
        drive2(4'h3);
        drive2(4'h5);
        chk("second end", out2, 16'h1000);
        drive2(4'hf);
        chk("second end", out2, 16'h0001);
        step(1);
        chk("second end", out2, 16'h2001);
        step(ACT);
        drive2(4'h5);
        drive2(4'h2);
        drive2(4'hf);
        step(1);
        chk("second end", out2, 16'h2003);
        step(8);
        finish_test();
    end
endmodule : sdram_command_bank_state_decoder_test
